// >>> core/flash_front_consts.svh
/*
  opcode values, array geometry and field positions for the serial flash front end.
  assumes nothing; definitions only.
*/
`ifndef FLASH_FRONT_CONSTS_SVH
`define FLASH_FRONT_CONSTS_SVH
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_STATUS    8'h05
`define OP_WRITE_STATUS   8'h01
`define OP_READ_DATA      8'h03
`define OP_FAST_READ      8'h0b
`define OP_DUAL_OUT_READ  8'h3b
`define OP_DUAL_IO_READ   8'hbb
`define OP_PAGE_PROGRAM   8'h02
`define OP_SECTOR_ERASE   8'h20
`define OP_SMALL_BLK_ERASE 8'h52
`define OP_LARGE_BLK_ERASE 8'hd8
`define OP_CHIP_ERASE_A   8'hc7
`define OP_CHIP_ERASE_B   8'h60
`define OP_POWER_DOWN     8'hb9
`define OP_RELEASE_PD     8'hab
`define OP_MAKER_ID       8'h90
`define OP_UNIQUE_ID      8'h4b
`define OP_STD_ID         8'h9f
`define CONT_MODE_ENTER   4'h2
`define CONT_RESET_WORD   16'hffff
`define PAGE_BYTES        9'h100
`define PAGES_PER_SECTOR  12'h010
`define PAGES_PER_SMALL   12'h080
`define PAGES_PER_LARGE   12'h100
`define PAGES_VAR0        12'h200
`define PAGES_VAR1        12'h400
`define PAGES_VAR2        12'h800
`define SECTORS_VAR0      8'h20
`define SECTORS_VAR1      8'h40
`define SECTORS_VAR2      8'h80
`define LARGE_VAR0        4'h2
`define LARGE_VAR1        4'h4
`define LARGE_VAR2        4'h8
`define ST_BUSY_BIT       0
`define ST_WEL_BIT        1
`define ST_GUARD_LSB      2
`define ST_LOCK_BIT       7
`define DEVICE_ID_VAL     8'h5a  // arbitrary value
`define MAKER_ID_VAL      8'ha5  // arbitrary value
`define SYNC_STAGES       2
`endif

// >>> core/flash_front_pkg.sv
/*
  types shared by the serial flash front end.
  assumes the constants header is compiled alongside.
*/
package flash_front_pkg;
  typedef enum logic [3:0] {
    PH_OPCODE, PH_ADDR, PH_MODE, PH_DUMMY, PH_READ, PH_WRITE, PH_STATUS_IN, PH_ID, PH_IGNORE
  } phase_t;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_READ, CMD_FAST, CMD_DUAL_OUT, CMD_DUAL_IO, CMD_PROGRAM, CMD_ERASE_SEC,
    CMD_ERASE_SMALL, CMD_ERASE_LARGE, CMD_ERASE_CHIP, CMD_STATUS, CMD_ID
  } cmd_t;
endpackage

// >>> core/pin_edge_if.sv
/*
  interface carrying synchronised pin levels and clock edge pulses.
  assumes one clock domain, ref_clk.
*/
`timescale 1ns/10ps
interface pin_edge_if;
  logic sclk_rise;   // serial clock rising edge pulse
  logic sclk_fall;   // serial clock falling edge pulse
  logic sclk_lvl;    // synchronised serial clock level
  logic sel_lvl;     // synchronised select, high when selected
  logic sel_fall;    // select just asserted
  logic pause_lvl;   // synchronised pause pin, low pauses
  logic lane0;       // synchronised lane zero
  logic lane1;       // synchronised lane one
  logic guard_pin_n; // synchronised write protect, low active
  modport src (output sclk_rise, sclk_fall, sclk_lvl, sel_lvl, sel_fall, pause_lvl, lane0,
               lane1, guard_pin_n);
  modport dst (input sclk_rise, sclk_fall, sclk_lvl, sel_lvl, sel_fall, pause_lvl, lane0,
               lane1, guard_pin_n);
endinterface // pin_edge_if

// >>> core/pin_sync.sv
/*
  two-flop synchronisers for every pin, plus edge detection on the second stage.
  assumes pins are asynchronous to ref_clk.
*/
`timescale 1ns/10ps
module pin_sync (
  // clock and control
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // raw pins
  input  wire logic [6:0] pins_in,
  // synchronised result
  pin_edge_if.src   sy
);
  logic [6:0] meta_ff;   // first stage, read only by second stage
  logic [6:0] sync_ff;   // second stage
  logic [6:0] last_ff;   // previous value for edge detection
  // pins: 0 sclk, 1 select_n, 2 pause_n, 3 lane0, 4 lane1, 5 wp_n
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_ff <= 7'h26;
      sync_ff <= 7'h26;
      last_ff <= 7'h26;
    end else if (clk_en) begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign sy.sclk_lvl    = sync_ff[0];
  assign sy.sclk_rise   = sync_ff[0] & ~last_ff[0];
  assign sy.sclk_fall   = ~sync_ff[0] & last_ff[0];
  assign sy.sel_lvl     = ~sync_ff[1];
  assign sy.sel_fall    = ~sync_ff[1] & last_ff[1];
  assign sy.pause_lvl   = sync_ff[2];
  assign sy.lane0       = sync_ff[3];
  assign sy.lane1       = sync_ff[4];
  assign sy.guard_pin_n = sync_ff[5];
endmodule // pin_sync

// >>> core/pause_ctrl.sv
/*
  pause state: enters and leaves only while the serial clock is low, except that deselect clears it at any clock level.
  assumes synchronised pin levels from pin_sync.
*/
`timescale 1ns/10ps
module pause_ctrl (
  // clock and control
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // pins
  pin_edge_if.dst   sy,
  // result
  output logic      paused
);
  logic paused_ff;  // current pause state
  wire  want_pause = sy.sel_lvl & ~sy.pause_lvl;  // pause requested
  // change state only when clock low, i.e. now or after next falling edge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      paused_ff <= 1'b0;
    end else if (clk_en) begin
      if (!sy.sel_lvl) begin
        paused_ff <= 1'b0;                        // deselect clears pause
      end else if (!sy.sclk_lvl) begin
        paused_ff <= want_pause;
      end
    end
  end
  assign paused = paused_ff;
endmodule // pause_ctrl

// >>> core/flash_front.sv
/*
  serial flash front end: instruction decode, address and mode capture, single and dual
  data lanes, pause, write protect gating and array geometry checks.
  assumes the host drives pins in bus mode 0 or 3; ref_clk oversamples the serial clock.
*/
`timescale 1ns/10ps
`include "flash_front_consts.svh"
module flash_front (
  // clock and control
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [1:0]  density_sel,
  // serial pins
  input  wire logic        sclk_pin,
  input  wire logic        select_n_pin,
  input  wire logic        pause_n_pin,
  input  wire logic        write_guard_n_pin,
  input  wire logic        dual_lane_zero_i,
  output logic             dual_lane_zero_o,
  output logic             dual_lane_zero_oe,
  input  wire logic        dual_lane_one_i,
  output logic             dual_lane_one_o,
  output logic             dual_lane_one_oe,
  // array side
  input  wire logic [7:0]  array_rdata,
  input  wire logic [7:0]  uid_byte,
  output logic [23:0]      array_addr,
  output logic [7:0]       array_wdata,
  output logic             array_write,
  output logic             erase_req,
  output logic [1:0]       erase_kind,
  output logic             power_down,
  output logic [7:0]       status_out
);
  pin_edge_if sy ();
  logic paused;
  pin_sync u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .pins_in ({1'b0, write_guard_n_pin, dual_lane_one_i, dual_lane_zero_i, pause_n_pin,
               select_n_pin, sclk_pin}),
    .sy      (sy)
  );
  pause_ctrl u_pause (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clk_en  (clk_en),
    .sy      (sy),
    .paused  (paused)
  );

  flash_front_pkg::phase_t phase_ff;     // transfer phase
  flash_front_pkg::cmd_t   cmd_ff;       // decoded instruction
  logic [7:0]  shift_in_ff;              // inbound shifter
  logic [7:0]  shift_out_ff;             // outbound shifter
  logic [5:0]  bit_cnt_ff;               // bits in current phase
  logic [23:0] addr_ff;                  // captured address
  logic [8:0]  prog_cnt_ff;              // bytes written in page program
  logic        armed_ff;                 // seen a select falling edge since reset
  logic        cont_mode_ff;             // continuous read active
  logic [15:0] reset_word_ff;            // watch for continuous-read reset word
  logic        wel_ff;                   // write enable latch
  logic [2:0]  guard_ff;                 // array guard bits
  logic        lock_ff;                  // status lock bit
  logic        pd_ff;                    // low-power state
  logic        d0_ff, d1_ff, oe0_ff, oe1_ff;
  logic [1:0]  id_idx_ff;                // identification byte index
  logic        write_ff, erase_ff;
  logic [1:0]  ekind_ff;

  // decode helpers
  wire active    = sy.sel_lvl & armed_ff & ~paused;
  wire rise      = active & sy.sclk_rise;
  wire fall      = active & sy.sclk_fall;
  wire dual_cmd  = (cmd_ff == flash_front_pkg::CMD_DUAL_OUT) |
                   (cmd_ff == flash_front_pkg::CMD_DUAL_IO);
  wire dual_in   = (cmd_ff == flash_front_pkg::CMD_DUAL_IO) &
                   ((phase_ff == flash_front_pkg::PH_ADDR) |
                    (phase_ff == flash_front_pkg::PH_MODE));
  wire [1:0] step = dual_in ? 2'd2 : 2'd1;
  wire [7:0] in_byte = dual_in ? {shift_in_ff[5:0], sy.lane1, sy.lane0}
                               : {shift_in_ff[6:0], sy.lane0};
  wire [5:0] cnt_nxt = bit_cnt_ff + {4'h0, step};
  wire byte_done = cnt_nxt[2:0] == 3'h0;
  // last fall of a read byte: after bit seven single, after the third pair dual
  wire rd_last = dual_cmd ? (bit_cnt_ff[1:0] == 2'd3) : (bit_cnt_ff[2:0] == 3'h7);
  wire hw_locked = lock_ff & ~sy.guard_pin_n;
  wire [11:0] max_pages = (density_sel == 2'd0) ? `PAGES_VAR0 :
                          (density_sel == 2'd1) ? `PAGES_VAR1 : `PAGES_VAR2;
  wire [11:0] page_of   = addr_ff[19:8];
  wire in_range = page_of < max_pages;
  // guard: guard_ff chooses top fraction 1/64..all of array protected
  wire [11:0] guard_floor = (guard_ff == 3'h0) ? 12'hfff :
                            (max_pages - (max_pages >> (3'h7 - guard_ff)));
  wire protected_pg = (guard_ff == 3'h7) | ((guard_ff != 3'h0) & (page_of >= guard_floor));
  wire may_write = wel_ff & in_range & ~protected_pg;
  wire [7:0] status_byte = {lock_ff, 1'b0, 1'b0, guard_ff, wel_ff, 1'b0};
  wire [7:0] id_byte = (id_idx_ff == 2'd0) ? `MAKER_ID_VAL : `DEVICE_ID_VAL;

  // opcode decode into command class
  function automatic flash_front_pkg::cmd_t decode(input logic [7:0] op);
    unique case (op)
      `OP_READ_DATA:       decode = flash_front_pkg::CMD_READ;
      `OP_FAST_READ:       decode = flash_front_pkg::CMD_FAST;
      `OP_DUAL_OUT_READ:   decode = flash_front_pkg::CMD_DUAL_OUT;
      `OP_DUAL_IO_READ:    decode = flash_front_pkg::CMD_DUAL_IO;
      `OP_PAGE_PROGRAM:    decode = flash_front_pkg::CMD_PROGRAM;
      `OP_SECTOR_ERASE:    decode = flash_front_pkg::CMD_ERASE_SEC;
      `OP_SMALL_BLK_ERASE: decode = flash_front_pkg::CMD_ERASE_SMALL;
      `OP_LARGE_BLK_ERASE: decode = flash_front_pkg::CMD_ERASE_LARGE;
      `OP_CHIP_ERASE_A,
      `OP_CHIP_ERASE_B:    decode = flash_front_pkg::CMD_ERASE_CHIP;
      `OP_READ_STATUS,
      `OP_WRITE_STATUS:    decode = flash_front_pkg::CMD_STATUS;
      `OP_RELEASE_PD,
      `OP_MAKER_ID,
      `OP_UNIQUE_ID,
      `OP_STD_ID:          decode = flash_front_pkg::CMD_ID;
      default:             decode = flash_front_pkg::CMD_NONE;
    endcase
  endfunction

  // arm after the first select falling edge
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      armed_ff <= 1'b0;
    end else if (clk_en && sy.sel_fall) begin
      armed_ff <= 1'b1;
    end
  end

  // inbound sequencing on rising serial clock edges
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_ff <= flash_front_pkg::PH_OPCODE;
      cmd_ff <= flash_front_pkg::CMD_NONE;
      shift_in_ff <= 8'h00;
      bit_cnt_ff <= 6'h00;
      addr_ff <= 24'h000000;
      prog_cnt_ff <= 9'h000;
      cont_mode_ff <= 1'b0;
      reset_word_ff <= 16'h0000;
      wel_ff <= 1'b0;
      guard_ff <= 3'h0;
      lock_ff <= 1'b0;
      pd_ff <= 1'b0;
      id_idx_ff <= 2'd0;
      write_ff <= 1'b0;
      erase_ff <= 1'b0;
      ekind_ff <= 2'd0;
    end else if (clk_en) begin
      write_ff <= 1'b0;
      if (write_ff) begin
        addr_ff[7:0] <= addr_ff[7:0] + 8'h01;                        // step after the byte lands
      end
      erase_ff <= 1'b0;
      if (!sy.sel_lvl) begin
        // deselect ends the instruction; erases commit here
        if (phase_ff == flash_front_pkg::PH_IGNORE && cmd_ff != flash_front_pkg::CMD_NONE
            && may_write) begin
          erase_ff <= 1'b1;
          wel_ff <= 1'b0;
        end
        phase_ff <= (cont_mode_ff) ? flash_front_pkg::PH_ADDR : flash_front_pkg::PH_OPCODE;
        cmd_ff <= cont_mode_ff ? cmd_ff : flash_front_pkg::CMD_NONE;
        bit_cnt_ff <= 6'h00;
        prog_cnt_ff <= 9'h000;
        id_idx_ff <= 2'd0;
        reset_word_ff <= 16'h0000;
      end else if (rise) begin
        shift_in_ff <= in_byte;
        bit_cnt_ff <= cnt_nxt;
        reset_word_ff <= {reset_word_ff[14:0], sy.lane0};
        if (cont_mode_ff && phase_ff == flash_front_pkg::PH_ADDR &&
            {reset_word_ff[14:0], sy.lane0} == `CONT_RESET_WORD && cnt_nxt == 6'd16) begin
          cont_mode_ff <= 1'b0;
          phase_ff <= flash_front_pkg::PH_IGNORE;
          cmd_ff <= flash_front_pkg::CMD_NONE;
        end else if (byte_done) begin
          unique case (phase_ff)
            flash_front_pkg::PH_OPCODE: begin
              bit_cnt_ff <= 6'h00;
              cmd_ff <= decode(in_byte);
              if (pd_ff && in_byte != `OP_RELEASE_PD) begin
                phase_ff <= flash_front_pkg::PH_IGNORE;
                cmd_ff <= flash_front_pkg::CMD_NONE;
              end else if (in_byte == `OP_WRITE_ENABLE) begin
                wel_ff <= 1'b1;
                phase_ff <= flash_front_pkg::PH_IGNORE;
              end else if (in_byte == `OP_WRITE_DISABLE) begin
                wel_ff <= 1'b0;
                phase_ff <= flash_front_pkg::PH_IGNORE;
              end else if (in_byte == `OP_POWER_DOWN) begin
                pd_ff <= 1'b1;
                phase_ff <= flash_front_pkg::PH_IGNORE;
              end else if (in_byte == `OP_RELEASE_PD) begin
                pd_ff <= 1'b0;
                phase_ff <= flash_front_pkg::PH_ID;
                id_idx_ff <= 2'd1;
              end else if (in_byte == `OP_READ_STATUS) begin
                phase_ff <= flash_front_pkg::PH_STATUS_IN;
              end else if (in_byte == `OP_WRITE_STATUS) begin
                phase_ff <= flash_front_pkg::PH_WRITE;
              end else if (in_byte == `OP_STD_ID || in_byte == `OP_UNIQUE_ID) begin
                phase_ff <= flash_front_pkg::PH_ID;
              end else if (decode(in_byte) == flash_front_pkg::CMD_ERASE_CHIP) begin
                addr_ff <= 24'h000000;
                ekind_ff <= 2'd3;
                phase_ff <= flash_front_pkg::PH_IGNORE;
              end else if (decode(in_byte) == flash_front_pkg::CMD_NONE) begin
                phase_ff <= flash_front_pkg::PH_IGNORE;
              end else begin
                phase_ff <= flash_front_pkg::PH_ADDR;
              end
            end
            flash_front_pkg::PH_ADDR: begin
              addr_ff <= {addr_ff[15:0], in_byte};
              if (cnt_nxt == 6'd24) begin
                bit_cnt_ff <= 6'h00;
                unique case (cmd_ff)
                  flash_front_pkg::CMD_READ: phase_ff <= flash_front_pkg::PH_READ;
                  flash_front_pkg::CMD_DUAL_IO: phase_ff <= flash_front_pkg::PH_MODE;
                  flash_front_pkg::CMD_FAST,
                  flash_front_pkg::CMD_DUAL_OUT: phase_ff <= flash_front_pkg::PH_DUMMY;
                  flash_front_pkg::CMD_PROGRAM: phase_ff <= flash_front_pkg::PH_WRITE;
                  flash_front_pkg::CMD_ID: phase_ff <= flash_front_pkg::PH_ID;
                  default: begin
                    ekind_ff <= (cmd_ff == flash_front_pkg::CMD_ERASE_SEC) ? 2'd0 :
                                (cmd_ff == flash_front_pkg::CMD_ERASE_SMALL) ? 2'd1 : 2'd2;
                    phase_ff <= flash_front_pkg::PH_IGNORE;
                  end
                endcase
              end
            end
            flash_front_pkg::PH_MODE: begin
              cont_mode_ff <= {2'b00, in_byte[5:4]} == `CONT_MODE_ENTER;
              phase_ff <= flash_front_pkg::PH_READ;
              bit_cnt_ff <= 6'h00;
            end
            flash_front_pkg::PH_DUMMY: begin
              phase_ff <= flash_front_pkg::PH_READ;
              bit_cnt_ff <= 6'h00;
            end
            flash_front_pkg::PH_WRITE: begin
              if (cmd_ff == flash_front_pkg::CMD_STATUS) begin
                if (wel_ff && !hw_locked) begin
                  guard_ff <= in_byte[4:2];
                  lock_ff <= in_byte[`ST_LOCK_BIT];
                end
                wel_ff <= 1'b0;
                phase_ff <= flash_front_pkg::PH_IGNORE;
              end else if (prog_cnt_ff < `PAGE_BYTES && may_write) begin
                write_ff <= 1'b1;
                prog_cnt_ff <= prog_cnt_ff + 9'h001;
              end
            end
            default: ;
          endcase
        end
      end else if (fall && rd_last && phase_ff == flash_front_pkg::PH_READ) begin
        addr_ff <= addr_ff + 24'h000001;                            // auto increment
      end else if (fall && phase_ff == flash_front_pkg::PH_ID && bit_cnt_ff[2:0] == 3'h7) begin
        id_idx_ff <= id_idx_ff + 2'd1;
      end
      if (prog_cnt_ff != 9'h000 && !sy.sel_lvl) begin
        wel_ff <= 1'b0;                                              // program ends write enable
      end
    end
  end

  // outbound drive on falling serial clock edges
  wire out_phase = (phase_ff == flash_front_pkg::PH_READ) |
                   (phase_ff == flash_front_pkg::PH_STATUS_IN) |
                   (phase_ff == flash_front_pkg::PH_ID);
  wire [7:0] load_byte = (phase_ff == flash_front_pkg::PH_STATUS_IN) ? status_byte :
                         (phase_ff == flash_front_pkg::PH_ID) ?
                         ((cmd_ff == flash_front_pkg::CMD_ID && id_idx_ff == 2'd3) ?
                          uid_byte : id_byte) : array_rdata;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      shift_out_ff <= 8'h00;
      d0_ff <= 1'b0;
      d1_ff <= 1'b0;
      oe0_ff <= 1'b0;
      oe1_ff <= 1'b0;
    end else if (clk_en) begin
      if (!sy.sel_lvl) begin
        oe0_ff <= 1'b0;
        oe1_ff <= 1'b0;
      end else if (fall && out_phase) begin
        if (dual_cmd && phase_ff == flash_front_pkg::PH_READ) begin
          {d1_ff, d0_ff} <= (bit_cnt_ff[1:0] == 2'd0) ? load_byte[7:6] : shift_out_ff[7:6];
          shift_out_ff <= (bit_cnt_ff[1:0] == 2'd0) ? {load_byte[5:0], 2'b00}
                                                     : {shift_out_ff[5:0], 2'b00};
          oe0_ff <= 1'b1;
          oe1_ff <= 1'b1;
        end else begin
          d1_ff <= (bit_cnt_ff[2:0] == 3'h0) ? load_byte[7] : shift_out_ff[7];
          shift_out_ff <= (bit_cnt_ff[2:0] == 3'h0) ? {load_byte[6:0], 1'b0}
                                                     : {shift_out_ff[6:0], 1'b0};
          oe0_ff <= 1'b0;
          oe1_ff <= 1'b1;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      array_addr <= 24'h000000;
      array_wdata <= 8'h00;
      array_write <= 1'b0;
      erase_req <= 1'b0;
      erase_kind <= 2'd0;
      power_down <= 1'b0;
      status_out <= 8'h00;
      dual_lane_zero_o <= 1'b0;
      dual_lane_zero_oe <= 1'b0;
      dual_lane_one_o <= 1'b0;
      dual_lane_one_oe <= 1'b0;
    end else if (clk_en) begin
      array_addr <= addr_ff;
      array_wdata <= shift_in_ff;
      array_write <= write_ff;
      erase_req <= erase_ff;
      erase_kind <= ekind_ff;
      power_down <= pd_ff;
      status_out <= status_byte;
      dual_lane_zero_o <= d0_ff;
      dual_lane_zero_oe <= oe0_ff & ~paused;                         // float in pause
      dual_lane_one_o <= d1_ff;
      dual_lane_one_oe <= oe1_ff & ~paused;                          // held bit returns
    end
  end
endmodule // flash_front

// >>> sim/flash_front_props.sv
/* pin-level checker for flash_front.
   assumes the bind at the foot; one clock domain, ref_clk. */
`timescale 1ns/10ps
module flash_front_props (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       sclk_pin,
  input wire logic       select_n_pin,
  input wire logic       pause_n_pin,
  input wire logic       dual_lane_zero_oe,
  input wire logic       dual_lane_one_oe,
  input wire logic       erase_req,
  input wire logic [7:0] status_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // deselect long enough for the synchroniser to settle
  sequence desel_s; select_n_pin [*6]; endsequence
  // pause held with the serial clock low
  sequence paused_s; (!pause_n_pin && !sclk_pin) [*8]; endsequence
  AST_DESEL_ONE: assert property (desel_s |-> !dual_lane_one_oe)
    else $error("lane one driven while deselected");
  AST_DESEL_ZERO: assert property (desel_s |-> !dual_lane_zero_oe)
    else $error("lane zero driven while deselected");
  AST_PAUSE_FLOAT: assert property (paused_s |-> !dual_lane_one_oe && !dual_lane_zero_oe)
    else $error("lane driven while paused");
  AST_RESET_CLEAN: assert property ($rose(resetn) |-> status_out == 8'h00)
    else $error("status not clear after reset");
  AST_ERASE_DESEL: assert property (erase_req |-> select_n_pin)
    else $error("erase issued while selected");
  AST_ERASE_PULSE: assert property (erase_req |=> !erase_req)
    else $error("erase request longer than one cycle");
  AST_STAT_STABLE: assert property (desel_s |=> $stable(status_out))
    else $error("status moved while idle");
  AST_STAT_ZEROS: assert property (status_out[6:5] == 2'h0 && !status_out[0])
    else $error("status spare bits set");
endmodule // flash_front_props
bind flash_front flash_front_props chk_u (.ref_clk(ref_clk), .resetn(resetn),
  .sclk_pin(sclk_pin), .select_n_pin(select_n_pin), .pause_n_pin(pause_n_pin),
  .dual_lane_zero_oe(dual_lane_zero_oe), .dual_lane_one_oe(dual_lane_one_oe),
  .erase_req(erase_req), .status_out(status_out));

// >>> sim/spi_host_model.sv
/* spi host model, bus mode 0, single lane.
   assumes ref_clk of the bench; serial clock runs only inside frames. */
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic ref_clk,
  input  wire logic lane_one,
  output logic      sclk,
  output logic      select_n,
  output logic      lane_zero,
  output logic      pause_n,
  output logic      guard_n
);
  initial begin
    {sclk, select_n, lane_zero, pause_n, guard_n} = 5'h0f;
  end
  // 320 ns serial clock, well inside the host clock limit
  // drive in the low phase, sample at the end of the high phase
  task automatic bit_cyc(input logic b, output logic r);
    lane_zero <= b;
    repeat (4) @(posedge ref_clk);
    sclk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    r = lane_one;
    sclk <= 1'b0;
  endtask
  // one byte, msb first
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_cyc(tx[i], rx[i]);
  endtask
  // select falls with the clock low
  task automatic frame_open();
    select_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // released data line shows a changed level
  task automatic frame_close();
    repeat (4) @(posedge ref_clk);
    select_n <= 1'b1;
    lane_zero <= ~lane_zero;
    repeat (8) @(posedge ref_clk);
  endtask
  // write protect level, changed between frames
  task automatic set_guard(input logic v);
    guard_n <= v;
    repeat (4) @(posedge ref_clk);
  endtask
  // pause with clock low, select kept low
  task automatic hold(input int n);
    pause_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    pause_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // spi_host_model

// >>> sim/flash_front_tb.sv
/* self-checking bench for flash_front.
   assumes spi_host_model on the pins and the bound checker. */
`timescale 1ns/10ps
`include "flash_front_consts.svh"
module flash_front_tb;
  logic        ref_clk, resetn, sclk, sel_n, pz, pause_n, guard_n;
  logic        flip = 1'b0;  // moving level on a released lane
  logic        l0_o, l0_oe, l1_o, l1_oe, awr, ereq, pdn;
  logic [1:0]  ekind, erase_last;
  logic [7:0]  awd, st, rb, wr_lo, wr_data;
  logic [23:0] aaddr;
  int          miscompares = 0, cmp_count = 0, erase_seen = 0;
  wire         lane0 = l0_oe ? l0_o : pz;
  wire         lane1 = l1_oe ? l1_o : flip;
  flash_front dut_u (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1), .density_sel(2'h2),
    .sclk_pin(sclk), .select_n_pin(sel_n), .pause_n_pin(pause_n),
    .write_guard_n_pin(guard_n), .dual_lane_zero_i(lane0), .dual_lane_zero_o(l0_o),
    .dual_lane_zero_oe(l0_oe), .dual_lane_one_i(lane1), .dual_lane_one_o(l1_o),
    .dual_lane_one_oe(l1_oe), .array_rdata(aaddr[7:0] ^ 8'h3c), .uid_byte(8'h00),
    .array_addr(aaddr), .array_wdata(awd), .array_write(awr), .erase_req(ereq),
    .erase_kind(ekind), .power_down(pdn), .status_out(st));
  spi_host_model host_u (.ref_clk(ref_clk), .lane_one(lane1), .sclk(sclk),
    .select_n(sel_n), .lane_zero(pz), .pause_n(pause_n), .guard_n(guard_n));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // moving idle level and erase request capture
  always @(posedge ref_clk) begin
    flip <= ~flip;
    if (ereq) begin
      erase_seen++;
      erase_last <= ekind;
    end
    if (awr) begin
      wr_lo <= aaddr[7:0];
      wr_data <= awd;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send24(input logic [23:0] a);
    for (int i = 2; i >= 0; i--) host_u.xbyte(a[i*8+:8], rb);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] exp, input logic rd);
    host_u.frame_open();
    host_u.xbyte(op, rb);
    if (rd) host_u.xbyte(8'h00, rb);
    host_u.frame_close();
    if (rd) chk(rb, exp);
  endtask
  // read across a page edge with a pause between the bytes
  task automatic t_read();
    host_u.frame_open();
    host_u.xbyte(`OP_READ_DATA, rb);
    send24(24'h0001ff);
    host_u.xbyte(8'h00, rb);
    chk(rb, 8'hff ^ 8'h3c);
    host_u.hold(12);
    host_u.xbyte(8'h00, rb);
    chk(rb, 8'h00 ^ 8'h3c);
    host_u.frame_close();
  endtask
  // every erase opcode, each after a write enable
  task automatic t_erase();
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    logic [1:0] kinds [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 5; i++) begin
      cmd(`OP_WRITE_ENABLE, 8'h00, 1'b0);
      host_u.frame_open();
      host_u.xbyte(ops[i], rb);
      if (kinds[i] != 2'h3) send24(24'h001000);
      host_u.frame_close();
      chk(8'(erase_seen), 8'(i + 1));
      chk({6'h00, erase_last}, {6'h00, kinds[i]});
    end
  endtask
  // one programmed byte lands at the low address byte sent, then write enable clears
  task automatic t_prog();
    cmd(`OP_WRITE_ENABLE, 8'h00, 1'b0);
    host_u.frame_open();
    host_u.xbyte(`OP_PAGE_PROGRAM, rb);
    send24(24'h000310);
    host_u.xbyte(8'h5a, rb);
    host_u.frame_close();
    chk(wr_lo, 8'h10);
    chk(wr_data, 8'h5a);
    cmd(`OP_READ_STATUS, 8'h00, 1'b1);
  endtask
  task automatic wr_status(input logic [7:0] v);
    cmd(`OP_WRITE_ENABLE, 8'h00, 1'b0);
    host_u.frame_open();
    host_u.xbyte(`OP_WRITE_STATUS, rb);
    host_u.xbyte(v, rb);
    host_u.frame_close();
  endtask
  // lock set and write protect low refuse a status write
  task automatic t_lock();
    wr_status(8'h9c);
    cmd(`OP_READ_STATUS, 8'h9c, 1'b1);
    host_u.set_guard(1'b0);
    wr_status(8'h00);
    cmd(`OP_READ_STATUS, 8'h9c, 1'b1);
    host_u.set_guard(1'b1);
    wr_status(8'h00);
    cmd(`OP_READ_STATUS, 8'h00, 1'b1);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_read();
    cmd(`OP_READ_STATUS, 8'h00, 1'b1);
    cmd(`OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`OP_READ_STATUS, 8'h02, 1'b1);
    t_erase();
    cmd(`OP_READ_STATUS, 8'h00, 1'b1);
    cmd(`OP_POWER_DOWN, 8'h00, 1'b0);
    chk({7'h00, pdn}, 8'h01);
    cmd(`OP_RELEASE_PD, 8'h00, 1'b0);
    chk({7'h00, pdn}, 8'h00);
    t_prog();
    t_lock();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // flash_front_tb
